// file: verilog/lsr_link_status.sv
`timescale 1ns/10ps
`default_nettype none
`include "lsr_map.svh"
module lsr_link_status #(
  parameter int MAX_LANES = 16
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [11:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Physical and link layer
  input  wire lsr_pkg::lsr_phy_s phy_i,
  input  wire logic              clk_mode_i,
  output logic                   retrain_o,
  // Interrupt
  output logic                   irq_o
);
  import lsr_pkg::*;

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic [7:0]  idx;
  logic        wr_en;
  logic        rd_word;
  lsr_word_t   ls_val;

  assign idx   = wb_adr_i[9:2];
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;

  // ----------------------------------------------------------------
  // Stored state
  // ----------------------------------------------------------------
  logic [9:0]  cfg_r;
  logic [9:0]  cfg_nxt;
  logic [3:0]  speed_r;
  logic [3:0]  speed_nxt;
  logic [5:0]  width_r;
  logic [5:0]  width_nxt;
  logic        dll_r;
  logic        dll_nxt;
  logic        train_r;
  logic        train_nxt;
  logic        cclk_r;
  logic        cclk_nxt;
  logic        bwm_r;
  logic        bwm_nxt;
  logic        abw_r;
  logic        abw_nxt;
  logic [1:0]  isr_r;
  logic [1:0]  isr_nxt;
  logic [1:0]  imr_r;
  logic [1:0]  imr_nxt;
  logic        irq_r;
  logic        irq_nxt;
  lsr_rt_e     rt_r;
  lsr_rt_e     rt_nxt;
  logic        down_r;
  logic        down_nxt;
  logic        rtp_r;
  logic        rtp_nxt;
  logic [2:0]  sync_r;
  logic        strap_r;
  logic        strap_nxt;
  logic [1:0]  fill_r;
  logic [1:0]  fill_nxt;

  logic        ds;
  logic        flag_ok;
  logic [5:0]  maxw;
  logic        maxw_ok;
  logic        rt_req;
  logic        rt_done;
  logic        set_bwm;
  logic        set_abw;
  logic        clr_bwm;
  logic        clr_abw;

  assign ds      = cfg_r[`LSR_CFG_DS];
  assign flag_ok = ds & cfg_r[`LSR_CFG_BWN];
  assign maxw    = cfg_r[`LSR_CFG_MAXW_HI:`LSR_CFG_MAXW_LO];

  // Widths this port can train to
  always_comb begin
    case (maxw)
      6'h01: maxw_ok = 1'b1;
      6'h02: maxw_ok = MAX_LANES >= 2;
      6'h04: maxw_ok = MAX_LANES >= 4;
      6'h08: maxw_ok = MAX_LANES >= 8;
      6'h0C: maxw_ok = MAX_LANES >= 12;
      6'h10: maxw_ok = MAX_LANES >= 16;
      6'h20: maxw_ok = MAX_LANES >= 32;
      default: maxw_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Register read view
  // ----------------------------------------------------------------
  always_comb begin
    ls_val                = 16'h0000;
    ls_val[3:0]           = speed_r;
    ls_val[9:4]           = width_r;
    ls_val[`LSR_ST_TRAIN] = train_r & ds;
    ls_val[`LSR_ST_CCLK]  = cclk_r;
    ls_val[`LSR_ST_DLL]   = dll_r & cfg_r[`LSR_CFG_DLLCAP];
    ls_val[`LSR_ST_BWM]   = bwm_r & flag_ok;
    ls_val[`LSR_ST_ABW]   = abw_r & flag_ok;
  end

  always_comb begin
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    rd_word = ack_nxt & ~wb_we_i;
    dat_nxt = 32'h0000_0000;
    if (rd_word) begin
      case (idx)
        `LSR_IDX_CFG:     dat_nxt = {22'h00_0000, cfg_r};
        `LSR_IDX_STATUS:  dat_nxt = {16'h0000, ls_val};
        `LSR_IDX_IRQ_STS: dat_nxt = {30'h0000_0000, isr_r};
        `LSR_IDX_IRQ_MSK: dat_nxt = {30'h0000_0000, imr_r};
        default:          dat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration, speed, width and data link state
  // ----------------------------------------------------------------
  always_comb begin
    cfg_nxt = cfg_r;
    imr_nxt = imr_r;
    if (wr_en && idx == `LSR_IDX_CFG) begin
      if (wb_sel_i[0])
        cfg_nxt[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1])
        cfg_nxt[9:8] = wb_dat_i[9:8];
    end
    if (wr_en && idx == `LSR_IDX_IRQ_MSK && wb_sel_i[0])
      imr_nxt = wb_dat_i[1:0];
    speed_nxt = phy_i.speed;
    if (!maxw_ok)
      width_nxt = maxw;
    else if (phy_i.train_fail)
      width_nxt = 6'h00;
    else
      width_nxt = phy_i.width;
    dll_nxt = phy_i.dll_active & cfg_r[`LSR_CFG_DLLCAP];
  end

  // ----------------------------------------------------------------
  // Retrain sequencing and training bit
  // ----------------------------------------------------------------
  assign rt_req = wr_en && idx == `LSR_IDX_CTRL && wb_sel_i[0] &&
                  wb_dat_i[`LSR_CTRL_RETRAIN];

  always_comb begin
    rt_nxt   = rt_r;
    down_nxt = down_r | phy_i.dl_down;
    rtp_nxt  = 1'b0;
    rt_done  = 1'b0;
    case (rt_r)
      RT_IDLE: begin
        if (rt_req) begin
          rt_nxt   = RT_PEND;
          rtp_nxt  = 1'b1;
          down_nxt = 1'b0;
        end
      end
      RT_PEND: begin
        if (phy_i.in_cfg_rec)
          rt_nxt = RT_TRAIN;
      end
      RT_TRAIN: begin
        if (!phy_i.in_cfg_rec) begin
          rt_nxt  = RT_IDLE;
          rt_done = ~down_nxt;
        end
      end
      default: rt_nxt = RT_IDLE;
    endcase
    // Set while training or retrain pending, clear on exit
    train_nxt = ds & (phy_i.in_cfg_rec | rt_nxt == RT_PEND);
  end

  // ----------------------------------------------------------------
  // Common clock bit
  // ----------------------------------------------------------------
  always_comb begin
    strap_nxt = strap_r;
    cclk_nxt  = cclk_r;
    fill_nxt  = fill_r + {1'b0, fill_r != `LSR_SYNC_FILL};
    // Capture only once the synchroniser has filled and its last two stages agree
    if (!strap_r && fill_r == `LSR_SYNC_FILL && sync_r[1] == sync_r[2]) begin
      strap_nxt = 1'b1;
      cclk_nxt  = sync_r[2];
    end else if (wr_en && idx == `LSR_IDX_STATUS && wb_sel_i[1] &&
                 !cfg_r[`LSR_CFG_LOCK]) begin
      cclk_nxt = wb_dat_i[`LSR_ST_CCLK];
    end
  end

  // ----------------------------------------------------------------
  // Bandwidth flags and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    set_bwm = flag_ok & (rt_done | phy_i.ev_reliab |
              (phy_i.ev_ds & ~phy_i.ev_ds_auto));
    set_abw = flag_ok & (phy_i.ev_auto |
              (phy_i.ev_ds & phy_i.ev_ds_auto));
    clr_bwm = wr_en && idx == `LSR_IDX_STATUS && wb_sel_i[1] &&
              wb_dat_i[`LSR_ST_BWM];
    clr_abw = wr_en && idx == `LSR_IDX_STATUS && wb_sel_i[1] &&
              wb_dat_i[`LSR_ST_ABW];
    // Set wins over a clear in the same cycle
    bwm_nxt = flag_ok & (set_bwm | (bwm_r & ~clr_bwm));
    abw_nxt = flag_ok & (set_abw | (abw_r & ~clr_abw));
    isr_nxt = isr_r;
    if (wr_en && idx == `LSR_IDX_IRQ_STS && wb_sel_i[0])
      isr_nxt = isr_r & ~wb_dat_i[1:0];
    if (set_bwm)
      isr_nxt[`LSR_IRQ_BWM] = 1'b1;
    if (set_abw)
      isr_nxt[`LSR_IRQ_ABW] = 1'b1;
    irq_nxt = |(isr_nxt & imr_nxt);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_r   <= 1'b0;
      dat_r   <= 32'h0000_0000;
      cfg_r   <= `LSR_CFG_RST;
      imr_r   <= 2'h0;
      isr_r   <= 2'h0;
      irq_r   <= 1'b0;
      speed_r <= `LSR_SPEED_RST;
      width_r <= 6'h00;
      dll_r   <= 1'b0;
      train_r <= 1'b0;
      cclk_r  <= 1'b0;
      strap_r <= 1'b0;
      sync_r  <= 3'h0;
      fill_r  <= 2'h0;
      bwm_r   <= 1'b0;
      abw_r   <= 1'b0;
      rt_r    <= RT_IDLE;
      down_r  <= 1'b0;
      rtp_r   <= 1'b0;
    end else begin
      ack_r   <= ack_nxt;
      dat_r   <= dat_nxt;
      cfg_r   <= cfg_nxt;
      imr_r   <= imr_nxt;
      isr_r   <= isr_nxt;
      irq_r   <= irq_nxt;
      speed_r <= speed_nxt;
      width_r <= width_nxt;
      dll_r   <= dll_nxt;
      train_r <= train_nxt;
      cclk_r  <= cclk_nxt;
      strap_r <= strap_nxt;
      sync_r  <= {sync_r[1:0], clk_mode_i};
      fill_r  <= fill_nxt;
      bwm_r   <= bwm_nxt;
      abw_r   <= abw_nxt;
      rt_r    <= rt_nxt;
      down_r  <= down_nxt;
      rtp_r   <= rtp_nxt;
    end
  end

  assign wb_ack_o  = ack_r;
  assign wb_dat_o  = dat_r;
  assign retrain_o = rtp_r;
  assign irq_o     = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  speed_follow_a: assert property (
    ##1 speed_r == $past(phy_i.speed))
    else $error("speed field not following phy");

  width_cap_a: assert property (
    !maxw_ok && $stable(maxw) |=> width_r == $past(maxw))
    else $error("unsupported width not reported");

  width_fail_a: assert property (
    maxw_ok && phy_i.train_fail |=> width_r == 6'h00)
    else $error("failed training width not zero");

  train_pend_a: assert property (
    rt_req && ds |=> ##1 ls_val[`LSR_ST_TRAIN])
    else $error("training bit missing after retrain");

  train_exit_a: assert property (
    rt_r == RT_IDLE && !phy_i.in_cfg_rec && !rt_req
      |=> !train_r)
    else $error("training bit stuck after exit");

  train_up_a: assert property (
    !ds |-> !ls_val[`LSR_ST_TRAIN])
    else $error("training bit seen in upstream mode");

  dll_cap_a: assert property (
    !cfg_r[`LSR_CFG_DLLCAP] |-> !ls_val[`LSR_ST_DLL])
    else $error("data link bit without capability");

  bwm_done_a: assert property (
    flag_ok && rt_r == RT_TRAIN && !phy_i.in_cfg_rec && !down_nxt
      ##1 flag_ok |-> bwm_r)
    else $error("retrain completion lost");

  abw_set_a: assert property (
    flag_ok && phy_i.ev_auto ##1 flag_ok |-> abw_r && isr_r[1])
    else $error("autonomous flag not set");

  flags_off_a: assert property (
    !flag_ok |=> !bwm_r && !abw_r)
    else $error("bandwidth flag outside capability");

  retrain_pulse_a: assert property (
    retrain_o |=> !retrain_o)
    else $error("retrain pulse too long");

  ack_one_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  width_follow_a: assert property (
    maxw_ok && !phy_i.train_fail |=> width_r == $past(phy_i.width))
    else $error("negotiated width not following phy");

  cclk_lock_a: assert property (
    strap_r && cfg_r[`LSR_CFG_LOCK] |=> $stable(cclk_r))
    else $error("locked common clock bit changed");

  dll_active_a: assert property (
    cfg_r[`LSR_CFG_DLLCAP] && phy_i.dll_active |=> dll_r)
    else $error("data link active not reported");

  bwm_reliab_a: assert property (
    flag_ok && phy_i.ev_reliab |=> bwm_r && isr_r[`LSR_IRQ_BWM])
    else $error("reliability change not flagged");

  bwm_ds_a: assert property (
    flag_ok && phy_i.ev_ds && !phy_i.ev_ds_auto |=> bwm_r)
    else $error("downstream change not flagged");

  retrain_c: cover property (rt_r == RT_TRAIN ##1 rt_r == RT_IDLE);
  bwm_c:     cover property (flag_ok && bwm_r && clr_bwm);
  irq_c:     cover property (irq_o);
  ds_ev_c:   cover property (flag_ok && phy_i.ev_ds && phy_i.ev_ds_auto);
  strap_c:   cover property (strap_nxt && !strap_r);
endmodule
`default_nettype wire

// file: shared/lsr_map.svh
// Summary of operation
// - Current speed field, resets to gen1
// - Negotiated lane count in six-bit field
// - Unsupported max width reports configured width
// - Supported width but training failed reads zero
// - Training bit set in Config/Recovery or pending
// - Training bit clears when LTSSM leaves
// - Training bit zero unless downstream port
// - Lockable common clock bit from clocking mode
// - Data link active bit, resets zero
// - Data link bit zero without capability
// - Retrain completion sets bandwidth flag, W1C
// - Reliability speed/width change sets bandwidth flag
// - Non-autonomous downstream change sets bandwidth flag
// - Autonomous change sets autonomous flag, W1C
// - Flags zero upstream or without notify
`ifndef LSR_MAP_SVH
`define LSR_MAP_SVH
`define LSR_IDX_CTRL     8'h50
`define LSR_IDX_CFG      8'h51
`define LSR_IDX_STATUS   8'h52
`define LSR_IDX_IRQ_STS  8'h53
`define LSR_IDX_IRQ_MSK  8'h54
`define LSR_CTRL_RETRAIN 5
`define LSR_CFG_DS       0
`define LSR_CFG_BWN      1
`define LSR_CFG_DLLCAP   2
`define LSR_CFG_LOCK     3
`define LSR_CFG_MAXW_LO  4
`define LSR_CFG_MAXW_HI  9
`define LSR_ST_TRAIN     11
`define LSR_ST_CCLK      12
`define LSR_ST_DLL       13
`define LSR_ST_BWM       14
`define LSR_ST_ABW       15
`define LSR_SPEED_RST    4'h1
`define LSR_CFG_RST      10'h011
`define LSR_SYNC_FILL    2'h3
`define LSR_IRQ_BWM      0
`define LSR_IRQ_ABW      1
`endif

// file: shared/lsr_pkg.sv
package lsr_pkg;
  // Port state delivered by the physical and link layers
  typedef struct packed {
    logic [3:0] speed;
    logic [5:0] width;
    logic       in_cfg_rec;
    logic       train_fail;
    logic       dl_down;
    logic       dll_active;
    logic       ev_reliab;
    logic       ev_auto;
    logic       ev_ds;
    logic       ev_ds_auto;
  } lsr_phy_s;
  typedef enum logic [1:0] {
    RT_IDLE,
    RT_PEND,
    RT_TRAIN
  } lsr_rt_e;
  typedef logic [15:0] lsr_word_t;
endpackage

// file: testbench/lsr_ltssm_model.sv
`timescale 1ns/10ps
`default_nettype none
module lsr_ltssm_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Retrain request and response delay
  input  wire logic       retrain_i,
  input  wire logic [3:0] delay_i,
  // Training state reported back
  output logic            rec_o
);
  logic [3:0] cnt_r;
  logic       pend_r;
  // ------------------------------------------------------------
  // Recovery sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r  <= 4'h0;
      pend_r <= 1'b0;
      rec_o  <= 1'b0;
    end else if (retrain_i) begin
      cnt_r  <= delay_i;
      pend_r <= 1'b1;
    end else if (pend_r) begin
      if (cnt_r == 4'h0) begin
        pend_r <= 1'b0;
        rec_o  <= 1'b1;
        cnt_r  <= 4'h6;
      end else begin
        cnt_r <= cnt_r - 4'h1;
      end
    end else if (rec_o && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else begin
      rec_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: testbench/lsr_link_status_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "lsr_map.svh"
module lsr_link_status_tb_top;
  import lsr_pkg::*;
  logic        clk_i;
  logic        reset_i;
  logic        cyc;
  logic        we;
  logic [11:0] adr;
  logic [31:0] dat;
  logic [3:0]  sel;
  logic [31:0] dat_o;
  logic        ack;
  lsr_phy_s    ph;
  lsr_phy_s    phy_w;
  logic [3:0]  ev;
  logic        rec;
  logic        retrain;
  logic        irq;
  logic [3:0]  dly;
  logic [31:0] rd;
  logic [5:0]  m;
  logic [5:0]  w;
  logic [3:0]  s;
  logic        f;
  logic        cmode;
  logic        cc;
  int          n_mismatch;
  int          tests_run;
  int          seed;
  logic [5:0]  tbl [9] = '{1, 2, 4, 8, 12, 16, 32, 3, 6};
  logic [3:0]  evt [4] = '{4'h1, 4'h2, 4'h4, 4'hC};

  always_comb begin
    phy_w            = ph;
    phy_w.in_cfg_rec = rec;
    phy_w.ev_reliab  = ev[0];
    phy_w.ev_auto    = ev[1];
    phy_w.ev_ds      = ev[2];
    phy_w.ev_ds_auto = ev[3];
  end

  lsr_link_status #(.MAX_LANES(16)) uut (
    .clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .phy_i(phy_w), .clk_mode_i(cmode),
    .retrain_o(retrain), .irq_o(irq)
  );
  lsr_ltssm_model ltssm (
    .clk_i(clk_i), .reset_i(reset_i), .retrain_i(retrain),
    .delay_i(dly), .rec_o(rec)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------
  // Expectations
  // ------------------------------------------------------------
  function automatic logic [5:0] ew(input logic [5:0] mx, wd,
                                    input logic fl);
    if (!(mx inside {1, 2, 4, 8, 12, 16}))
      return mx;
    return fl ? 6'h00 : wd;
  endfunction
  function automatic logic [31:0] st(input logic [3:0] sp,
      input logic [5:0] wd, input logic t, d, b, a);
    return {16'h0000, a, b, d, cc, t, 1'b0, wd, sp};
  endfunction

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic wrap_up;
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic tmo;
    $display("MISMATCH wait expected done seen timeout");
    n_mismatch++;
    wrap_up;
  endtask
  task automatic wb(input logic wr, input logic [7:0] i,
                    input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we  <= wr;
    adr <= {2'b00, i, 2'b00};
    dat <= {16'h0000, d};
    sel <= 4'h3;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20)
      tmo;
    rd = dat_o;
    @(posedge clk_i);
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] i,
                     input logic [31:0] e);
    wb(1'b0, i, 16'h0000);
    chk(nm, e, rd);
  endtask
  task automatic wrec(input logic v);
    int n;
    n = 0;
    while (rec !== v && n < 100) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 100)
      tmo;
  endtask
  task automatic pulse(input logic [3:0] e);
    @(posedge clk_i);
    ev <= e;
    @(posedge clk_i);
    ev <= 4'h0;
    repeat (3) @(posedge clk_i);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'hef03a3e2;
    n_mismatch = 0;
    tests_run = 0;
    {cyc, we, adr, dat, sel, ev} = '0;
    ph = '0;
    ph.speed = 4'h1;
    ph.width = 6'h01;
    dly = 4'h6;
    cmode = 1'b1;
    cc = 1'b1;
    reset_i = 1'b1;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rdc("status", `LSR_IDX_STATUS, st(1, 1, 0, 0, 0, 0));
    rdc("cfg", `LSR_IDX_CFG, 32'h0000_0011);
    wb(1'b1, `LSR_IDX_CFG, 16'h010F);
    wb(1'b1, `LSR_IDX_STATUS, 16'h2FFF);
    rdc("ro bits", `LSR_IDX_STATUS, st(1, 1, 0, 0, 0, 0));
    rdc("unmapped", 8'h60, 32'h0000_0000);
    for (int k = 0; k < 16; k++) begin
      m = tbl[$unsigned($random(seed)) % 9];
      w = tbl[$unsigned($random(seed)) % 6];
      s = 4'h1 + 4'($random(seed) & 1);
      f = 1'($random(seed));
      wb(1'b1, `LSR_IDX_CFG, {6'h00, m, 4'hF});
      ph.speed <= s;
      ph.width <= w;
      ph.train_fail <= f;
      repeat (3) @(posedge clk_i);
      rdc("speed width", `LSR_IDX_STATUS, st(s, ew(m, w, f), 0, 0, 0, 0));
    end
    ph.speed <= 4'h1;
    ph.width <= 6'h01;
    ph.train_fail <= 1'b0;
    wb(1'b1, `LSR_IDX_CFG, 16'h010F);
    dly <= 4'(6 + $unsigned($random(seed)) % 4);
    wb(1'b1, `LSR_IDX_CTRL, 16'h0020);
    rdc("pending", `LSR_IDX_STATUS, st(1, 1, 1, 0, 0, 0));
    rdc("ctrl", `LSR_IDX_CTRL, 32'h0000_0000);
    wrec(1'b1);
    rdc("training", `LSR_IDX_STATUS, st(1, 1, 1, 0, 0, 0));
    wrec(1'b0);
    repeat (3) @(posedge clk_i);
    rdc("retrained", `LSR_IDX_STATUS, st(1, 1, 0, 0, 1, 0));
    rdc("irq sts", `LSR_IDX_IRQ_STS, 32'h0000_0001);
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    wb(1'b1, `LSR_IDX_IRQ_MSK, 16'h0001);
    repeat (2) @(posedge clk_i);
    #1 chk("irq", 32'h1, {31'h0, irq});
    wb(1'b1, `LSR_IDX_IRQ_STS, 16'h0001);
    repeat (2) @(posedge clk_i);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    wb(1'b1, `LSR_IDX_STATUS, 16'h4000);
    dly <= 4'h0;
    wb(1'b1, `LSR_IDX_CTRL, 16'h0020);
    ph.dl_down <= 1'b1;
    @(posedge clk_i);
    ph.dl_down <= 1'b0;
    wrec(1'b1);
    wrec(1'b0);
    repeat (3) @(posedge clk_i);
    rdc("link down", `LSR_IDX_STATUS, st(1, 1, 0, 0, 0, 0));
    for (int k = 0; k < 4; k++) begin
      pulse(evt[k]);
      rdc("events", `LSR_IDX_STATUS, st(1, 1, 0, 0, k == 0 || k == 2, k == 1 || k == 3));
      wb(1'b1, `LSR_IDX_STATUS, 16'hC000);
    end
    rdc("w1c", `LSR_IDX_STATUS, st(1, 1, 0, 0, 0, 0));
    wb(1'b1, `LSR_IDX_CFG, 16'h010E);
    wb(1'b1, `LSR_IDX_CTRL, 16'h0020);
    rdc("upstream", `LSR_IDX_STATUS, st(1, 1, 0, 0, 0, 0));
    repeat (24) @(posedge clk_i);
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, `LSR_IDX_CFG, k ? 16'h010D : 16'h010E);
      pulse(4'h3);
      rdc("hidden", `LSR_IDX_STATUS, st(1, 1, 0, 0, 0, 0));
    end
    wb(1'b1, `LSR_IDX_CFG, 16'h010B);
    ph.dll_active <= 1'b1;
    repeat (2) @(posedge clk_i);
    rdc("dll nocap", `LSR_IDX_STATUS, st(1, 1, 0, 0, 0, 0));
    wb(1'b1, `LSR_IDX_CFG, 16'h010F);
    rdc("dll", `LSR_IDX_STATUS, st(1, 1, 0, 1, 0, 0));
    cmode <= 1'b0;
    reset_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    cc = 1'b0;
    repeat (5) @(posedge clk_i);
    rdc("strap low", `LSR_IDX_STATUS, st(1, 1, 0, 0, 0, 0));
    wb(1'b1, `LSR_IDX_STATUS, 16'h1000);
    cc = 1'b1;
    rdc("cclk write", `LSR_IDX_STATUS, st(1, 1, 0, 0, 0, 0));
    wrap_up;
  end
endmodule
`default_nettype wire
